// ### pkg/ict_pkg.sv
// package: opcodes, timing counts, status word layout for the channel engine
package ict_pkg;

  // --------------------------------------------------------------------
  // instruction opcodes (block-level encoding)
  // --------------------------------------------------------------------
  localparam logic [4:0] OP_NO_OPERATION      = 5'h00;
  localparam logic [4:0] OP_HALT              = 5'h01;
  localparam logic [4:0] OP_INTERRUPT_REQUEST = 5'h02;
  localparam logic [4:0] OP_SET_WIDTHS        = 5'h03;
  localparam logic [4:0] OP_JUMP_WORD_NZ      = 5'h04;
  localparam logic [4:0] OP_JUMP_WORD_Z       = 5'h05;
  localparam logic [4:0] OP_JUMP_BYTE_NZ      = 5'h06;
  localparam logic [4:0] OP_JUMP_BIT_CLEAR    = 5'h07;
  localparam logic [4:0] OP_JUMP_MCE          = 5'h08;
  localparam logic [4:0] OP_LONG_JUMP_MCNE    = 5'h09;
  localparam logic [4:0] OP_AND_REG_MEM       = 5'h0A;
  localparam logic [4:0] OP_AND_MEM_REG       = 5'h0B;
  localparam logic [4:0] OP_CALL              = 5'h0C;
  localparam logic [4:0] OP_TEST_AND_SET      = 5'h0D;
  localparam logic [4:0] OP_JUMP              = 5'h0E;

  // --------------------------------------------------------------------
  // execution clock counts
  // --------------------------------------------------------------------
  localparam logic [5:0] CLK_NO_OPERATION = 6'h04;
  localparam logic [5:0] CLK_HALT         = 6'h0B;
  localparam logic [5:0] CLK_INTR_REQ     = 6'h04;
  localparam logic [5:0] CLK_SET_WIDTHS   = 6'h04;
  localparam logic [5:0] CLK_JUMP_REG     = 6'h05;
  localparam logic [5:0] CLK_JUMP_MEM_S   = 6'h0C;
  localparam logic [5:0] CLK_JUMP_MEM_L   = 6'h10;
  localparam logic [5:0] CLK_JUMP_BYTE    = 6'h0C;
  localparam logic [5:0] CLK_JUMP_BIT     = 6'h0E;
  localparam logic [5:0] CLK_JUMP_MC      = 6'h0E;
  localparam logic [5:0] CLK_AND_RM_S     = 6'h0B;
  localparam logic [5:0] CLK_AND_RM_L     = 6'h0F;
  localparam logic [5:0] CLK_AND_MR_S     = 6'h10;
  localparam logic [5:0] CLK_AND_MR_L     = 6'h1A;
  localparam logic [5:0] CLK_CALL_S       = 6'h11;
  localparam logic [5:0] CLK_CALL_L       = 6'h17;
  localparam logic [5:0] CLK_TSL_NZ       = 6'h0E;
  localparam logic [5:0] CLK_TSL_Z        = 6'h10;
  localparam logic [5:0] CLK_JUMP         = 6'h03;

  // --------------------------------------------------------------------
  // channel status word fields and reset value
  // --------------------------------------------------------------------
  localparam int         SW_SRC_WIDTH_BIT = 0;
  localparam int         SW_DST_WIDTH_BIT = 1;
  localparam int         SW_INT_CTRL_BIT  = 2;
  localparam int         SW_INT_SVC_BIT   = 3;
  localparam logic [7:0] SW_RESET         = 8'h00;
  localparam logic [23:0] TP_RESET        = 24'h000000;

  // engine states
  typedef enum logic [1:0] {
    ICT_IDLE,
    ICT_FETCH,
    ICT_EXEC,
    ICT_DONE
  } ict_state_t;

endpackage

// ### sim/ict_bus_partner.sv
// bus partner model: grant and ready with commanded stalls
`timescale 1ns/100ps
`default_nettype none
module ict_bus_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // stall command from the bench
  input  wire logic       stall_go,
  input  wire logic       stall_wait,
  input  wire logic [3:0] stall_len,
  // bus handshake toward the channel
  output logic            bus_grant,
  output logic            mem_ready
);
  logic [3:0] left;  // stall cycles still to run
  logic       kind;  // 1: wait states, 0: lost arbitration
  // count a stall down once commanded
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 4'h0;
      kind <= 1'b0;
    end else if (stall_go) begin
      left <= stall_len;
      kind <= stall_wait;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  // withhold grant or ready while the stall runs
  assign bus_grant = !(left != 4'h0 && !kind);
  assign mem_ready = !(left != 4'h0 && kind);
endmodule
`default_nettype wire

// ### sim/ict_channel_monitor.sv
// checker: handshake, timing and interrupt properties of the channel
`timescale 1ns/100ps
`default_nettype none
module ict_channel_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // issue handshake
  input wire logic       issue_valid,
  input wire logic       issue_ready,
  // results
  input wire logic       busy,
  input wire logic       channel_interrupt_request,
  input wire logic [7:0] channel_status_word,
  input wire logic       save_we,
  input wire logic       result_we,
  input wire logic       width_error,
  input wire logic       instr_done,
  input wire logic [6:0] instr_total_clocks
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // --------------------------------------------------------------------
  // sequences
  // --------------------------------------------------------------------
  // an instruction is taken
  sequence s_take;
    issue_valid && issue_ready;
  endsequence
  // completion is a single-cycle pulse
  sequence s_done_pulse;
    instr_done ##1 !instr_done;
  endsequence
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  a_done_pulse: assert property (instr_done |-> s_done_pulse)
    else $error("completion pulse too long");
  a_ready_held: assert property (s_take |=> (!issue_ready) [*4])
    else $error("issue accepted again too early");
  a_busy_on_take: assert property (s_take |=> busy)
    else $error("busy not raised after issue");
  a_ready_at_done: assert property (instr_done |-> issue_ready)
    else $error("not ready at completion");
  a_total_floor: assert property (
    instr_done |-> instr_total_clocks >= 7'h04)
    else $error("total clocks below fetch plus execution");
  a_save_with_done: assert property (save_we |-> instr_done)
    else $error("save write outside completion");
  a_result_with_done: assert property (result_we |-> instr_done)
    else $error("result write outside completion");
  a_irq_rise: assert property ($rose(channel_interrupt_request) |->
    instr_done && channel_status_word[3] && channel_status_word[2])
    else $error("interrupt raised without request and control");
  a_irq_gated: assert property (!channel_status_word[2] |->
    !channel_interrupt_request)
    else $error("interrupt raised while disabled");
  a_width_hold: assert property ($rose(width_error) |->
    channel_status_word[1:0] == $past(channel_status_word[1:0]))
    else $error("widths changed by invalid code");
endmodule
bind ict_channel ict_channel_monitor u_mon (
  .clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .busy(busy),
  .channel_interrupt_request(channel_interrupt_request),
  .channel_status_word(channel_status_word), .save_we(save_we),
  .result_we(result_we), .width_error(width_error),
  .instr_done(instr_done), .instr_total_clocks(instr_total_clocks));
`default_nettype wire

// ### sim/tb_top.sv
// testbench: timing, interrupt, width and transfer checks of the channel
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rst_b, issue_valid, operand_is_reg, operand_odd;
  logic        bus_is_8bit, long_form, int_control_in, int_control_we;
  logic        bus_grant, mem_ready, stall_go, stall_wait;
  logic [4:0]  issue_opcode, width_code;
  logic [5:0]  fetch_clocks;
  logic [2:0]  bit_select, instr_length;
  logic [15:0] displacement, src_value, dst_value, mask_compare;
  logic [7:0]  set_value, sw;
  logic [3:0]  stall_len;
  logic        issue_ready, busy, irq, save_we, result_we, werr, done;
  logic [23:0] task_pointer, ret_save;
  logic [15:0] result_value;
  logic [6:0]  total;
  int          failures, n_checks;
  // op, {reg, odd, narrow}, execution clocks
  localparam logic [13:0] TBL [17] = '{
    {ict_pkg::OP_NO_OPERATION, 3'h0, 6'h04},
    {ict_pkg::OP_HALT, 3'h0, 6'h0B},
    {ict_pkg::OP_JUMP_WORD_NZ, 3'h4, 6'h05},
    {ict_pkg::OP_JUMP_WORD_NZ, 3'h0, 6'h0C},
    {ict_pkg::OP_JUMP_WORD_NZ, 3'h2, 6'h10},
    {ict_pkg::OP_JUMP_WORD_NZ, 3'h1, 6'h10},
    {ict_pkg::OP_JUMP_WORD_Z, 3'h4, 6'h05},
    {ict_pkg::OP_JUMP_WORD_Z, 3'h0, 6'h0C},
    {ict_pkg::OP_JUMP_WORD_Z, 3'h1, 6'h10},
    {ict_pkg::OP_JUMP_BYTE_NZ, 3'h0, 6'h0C},
    {ict_pkg::OP_JUMP_BIT_CLEAR, 3'h0, 6'h0E},
    {ict_pkg::OP_JUMP_MCE, 3'h0, 6'h0E},
    {ict_pkg::OP_LONG_JUMP_MCNE, 3'h0, 6'h0E},
    {ict_pkg::OP_AND_REG_MEM, 3'h0, 6'h0B},
    {ict_pkg::OP_AND_REG_MEM, 3'h2, 6'h0F},
    {ict_pkg::OP_AND_MEM_REG, 3'h0, 6'h10},
    {ict_pkg::OP_AND_MEM_REG, 3'h1, 6'h1A}};
  ict_channel dut (
    .clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .fetch_clocks(fetch_clocks),
    .operand_is_reg(operand_is_reg), .operand_odd(operand_odd),
    .bus_is_8bit(bus_is_8bit), .long_form(long_form),
    .displacement(displacement), .bit_select(bit_select),
    .width_code(width_code), .instr_length(instr_length),
    .src_value(src_value), .dst_value(dst_value),
    .mask_compare(mask_compare), .set_value(set_value),
    .int_control_in(int_control_in), .int_control_we(int_control_we),
    .bus_grant(bus_grant), .mem_ready(mem_ready),
    .issue_ready(issue_ready), .busy(busy),
    .channel_interrupt_request(irq), .channel_status_word(sw),
    .task_pointer(task_pointer), .return_address_save(ret_save),
    .save_we(save_we), .result_value(result_value),
    .result_we(result_we), .width_error(werr), .instr_done(done),
    .instr_total_clocks(total));
  ict_bus_partner u_bus (
    .clk(clk), .rst_b(rst_b), .stall_go(stall_go),
    .stall_wait(stall_wait), .stall_len(stall_len),
    .bus_grant(bus_grant), .mem_ready(mem_ready));
  // free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare one value and count it
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // report counts and close the run
  task end_sim;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // issue one instruction and wait for completion, check total clocks
  task run_op(input logic [4:0] op, input logic [5:0] f,
              input logic [5:0] e);
    int n;
    @(posedge clk);
    issue_valid  <= 1'b1;
    issue_opcode <= op;
    fetch_clocks <= f;
    @(posedge clk);
    issue_valid <= 1'b0;
    stall_go    <= (stall_len != 4'h0);
    @(posedge clk);
    stall_go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    if (n >= 200) begin
      failures++;
      end_sim();
    end else begin
      chk(total, 7'(f) + 7'(e) + 7'(stall_len));
    end
  endtask
  // write the interrupt control bit
  task set_ctrl(input logic v);
    @(posedge clk);
    int_control_in <= v;
    int_control_we <= 1'b1;
    @(posedge clk);
    int_control_we <= 1'b0;
  endtask
  // main sequence
  initial begin
    {rst_b, issue_valid, operand_is_reg, operand_odd, bus_is_8bit} = '0;
    {long_form, int_control_in, int_control_we, stall_go} = '0;
    {stall_wait, stall_len, issue_opcode, width_code} = '0;
    {fetch_clocks, bit_select, displacement, src_value} = '0;
    {dst_value, set_value} = '0;
    mask_compare = 16'hFF00;
    instr_length = 3'h2;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({issue_ready, busy, irq, sw}, {3'h4, ict_pkg::SW_RESET});
    chk(task_pointer, ict_pkg::TP_RESET);
    // timing table, fetch time varied per entry
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      {operand_is_reg, operand_odd, bus_is_8bit} <= TBL[i][8:6];
      run_op(TBL[i][13:9], 6'(i + 1), TBL[i][5:0]);
      if (i < 2)
        chk({busy, save_we, result_we, sw}, {i == 0, 10'h0});
    end
    // interrupt request with control set, then cleared
    set_ctrl(1'b1);
    run_op(ict_pkg::OP_INTERRUPT_REQUEST, 6'h03, 6'h04);
    chk({irq, sw[3]}, 2'h3);
    set_ctrl(1'b0);
    @(negedge clk);
    chk(irq, 1'b0);
    run_op(ict_pkg::OP_INTERRUPT_REQUEST, 6'h03, 6'h04);
    chk({irq, sw[3]}, 2'h1);
    // logical widths: both 16, dst 16 only, then an invalid code
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      width_code <= (i == 0) ? 5'h18 : (i == 1) ? 5'h08 : 5'h19;
      run_op(ict_pkg::OP_SET_WIDTHS, 6'h02, 6'h04);
      chk({werr, sw[1:0]}, (i == 0) ? 3'h3 : (i == 1) ? 3'h2 : 3'h6);
    end
    // second reset, then transfers from a known pointer
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b        <= 1'b1;
    instr_length <= 3'h3;
    displacement <= 16'h0080;
    run_op(ict_pkg::OP_CALL, 6'h02, 6'h11);
    chk({save_we, ret_save}, 25'h1000003);
    chk(task_pointer, 24'hFFFF83);
    @(posedge clk);
    {long_form, instr_length, displacement} <= {1'b1, 3'h4, 16'h7FFF};
    run_op(ict_pkg::OP_JUMP, 6'h02, 6'h03);
    chk(task_pointer, 24'h007F86);
    @(posedge clk);
    {long_form, instr_length, displacement} <= {1'b0, 3'h3, 16'h0010};
    {src_value, bit_select} <= {16'h007F, 3'h7};
    run_op(ict_pkg::OP_JUMP_BIT_CLEAR, 6'h02, 6'h0E);
    chk(task_pointer, 24'h007F99);
    @(posedge clk);
    bit_select <= 3'h0;
    run_op(ict_pkg::OP_JUMP_BIT_CLEAR, 6'h02, 6'h0E);
    chk(task_pointer, 24'h007F9C);
    // test-and-set on a free and on a held semaphore
    @(posedge clk);
    {dst_value, set_value} <= {16'h0000, 8'hA5};
    run_op(ict_pkg::OP_TEST_AND_SET, 6'h02, 6'h10);
    chk({result_we, result_value[7:0]}, 9'h1A5);
    @(posedge clk);
    dst_value <= 16'h0005;
    run_op(ict_pkg::OP_TEST_AND_SET, 6'h02, 6'h0E);
    chk(result_we, 1'b0);
    // word and into a register
    @(posedge clk);
    {src_value, dst_value} <= {16'hF0F3, 16'h3C3C};
    bus_is_8bit <= 1'b0;
    run_op(ict_pkg::OP_AND_REG_MEM, 6'h02, 6'h0B);
    chk({result_we, result_value}, 17'h13030);
    run_op(ict_pkg::OP_LONG_JUMP_MCNE, 6'h02, 6'h0E);
    chk(task_pointer, 24'h007FC8);
    // stalls by wait states, then by lost arbitration
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {operand_odd, stall_wait, stall_len} <= {1'b1, i == 0, 4'h5};
      run_op(ict_pkg::OP_AND_MEM_REG, 6'h02, 6'h1A);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// ### src/ict_channel.sv
// channel instruction executor with per-instruction execution timing
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - interrupt request sets service bit, raises output
// - control bit clear: service bit only
// - no-operation only steps the pointer to the next address, just waits
// - halt clears busy, idles, 11 clocks
// - aligned 16-bit word short, else long; call ignores bus width
// - total time is fetch plus execution
// - bus stalls lengthen elapsed time
// - bit select 0 is LSB, 7 MSB
// - call saves next address, 24 bits
// - test-and-set writes only when zero
// - short target: signed byte displacement
// - long target: signed 16-bit displacement
// - width operands only 8 or 16
// - source operand never modified
// - destination receives operation result
// - masked compare equal jump 14 clocks
// - word nonzero jump 5 or 12/16
// - word zero jump 5 or 12/16
// - byte nonzero jump 12 clocks
// - bit clear jump 14 clocks
// - long masked compare not equal 14
// - word and: 11/15 or 16/26 clocks
// - no-operation takes 4 clocks
module ict_channel (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // instruction issue from fetch unit
  input  wire logic        issue_valid,
  input  wire logic [4:0]  issue_opcode,
  input  wire logic [5:0]  fetch_clocks,
  input  wire logic        operand_is_reg,
  input  wire logic        operand_odd,
  input  wire logic        bus_is_8bit,
  input  wire logic        long_form,
  input  wire logic [15:0] displacement,
  input  wire logic [2:0]  bit_select,
  input  wire logic [4:0]  width_code,
  input  wire logic [2:0]  instr_length,
  // operand values
  input  wire logic [15:0] src_value,
  input  wire logic [15:0] dst_value,
  input  wire logic [15:0] mask_compare,
  input  wire logic [7:0]  set_value,
  input  wire logic        int_control_in,
  input  wire logic        int_control_we,
  // bus handshake from system bus (other domain, synchronised)
  input  wire logic        bus_grant,
  input  wire logic        mem_ready,
  // result outputs
  output logic             issue_ready,
  output logic             busy,
  output logic             channel_interrupt_request,
  output logic [7:0]       channel_status_word,
  output logic [23:0]      task_pointer,
  output logic [23:0]      return_address_save,
  output logic             save_we,
  output logic [15:0]      result_value,
  output logic             result_we,
  output logic             width_error,
  output logic             instr_done,
  output logic [6:0]       instr_total_clocks
);

  // --------------------------------------------------------------------
  // state record
  // --------------------------------------------------------------------
  typedef struct packed {
    ict_pkg::ict_state_t st;          // engine state
    logic [1:0]  gnt_sync;            // grant synchroniser
    logic [1:0]  rdy_sync;            // ready synchroniser
    logic [5:0]  fetch_left;          // fetch clocks remaining
    logic [5:0]  exec_left;           // execution clocks remaining
    logic [6:0]  elapsed;             // clocks spent on this instruction
    logic [4:0]  op;                  // latched opcode
    logic        taken;               // transfer decision
    logic [23:0] tp;                  // task pointer
    logic [23:0] tp_next;             // next sequential address
    logic [15:0] disp;                // latched displacement
    logic        lng;                 // long form flag
    logic [7:0]  sw;                  // channel status word
    logic        busy;                // program running
    logic        irq;                 // interrupt output
    logic        ready;               // accepts issue
    logic [23:0] save;                // return address out
    logic        save_we;             // save strobe
    logic [15:0] res;                 // result value
    logic        res_we;              // result strobe
    logic        werr;                // width operand rejected
    logic        done;                // completion pulse
    logic [6:0]  total;               // elapsed clocks reported
  } ict_regs_t;

  // one record holds every flop of the block
  ict_regs_t r;        // registered state
  ict_regs_t next_r;   // next state

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // pick short or long count from word alignment and bus width
  function automatic logic [5:0] word_clocks(input logic odd,
                                             input logic narrow,
                                             input logic [5:0] s,
                                             input logic [5:0] l);
    word_clocks = (odd || narrow) ? l : s;
  endfunction

  // sign extend a short or long displacement onto the pointer width
  function automatic logic [23:0] sext_disp(input logic lf,
                                            input logic [15:0] d);
    if (lf) begin
      sext_disp = {{8{d[15]}}, d};
    end else begin
      sext_disp = {{16{d[7]}}, d[7:0]};
    end
  endfunction

  // execution count for an opcode
  // unknown opcodes fall back to no-operation
  function automatic logic [5:0] exec_clocks(input logic [4:0] op,
                                             input logic is_reg,
                                             input logic odd,
                                             input logic narrow,
                                             input logic dzero);
    case (op)
      ict_pkg::OP_NO_OPERATION:      exec_clocks = ict_pkg::CLK_NO_OPERATION;
      ict_pkg::OP_HALT:              exec_clocks = ict_pkg::CLK_HALT;
      ict_pkg::OP_INTERRUPT_REQUEST: exec_clocks = ict_pkg::CLK_INTR_REQ;
      ict_pkg::OP_SET_WIDTHS:        exec_clocks = ict_pkg::CLK_SET_WIDTHS;
      ict_pkg::OP_JUMP_WORD_NZ,
      ict_pkg::OP_JUMP_WORD_Z:       exec_clocks = is_reg ?
          ict_pkg::CLK_JUMP_REG :
          word_clocks(odd, narrow, ict_pkg::CLK_JUMP_MEM_S,
                      ict_pkg::CLK_JUMP_MEM_L);
      ict_pkg::OP_JUMP_BYTE_NZ:      exec_clocks = ict_pkg::CLK_JUMP_BYTE;
      ict_pkg::OP_JUMP_BIT_CLEAR:    exec_clocks = ict_pkg::CLK_JUMP_BIT;
      ict_pkg::OP_JUMP_MCE:          exec_clocks = ict_pkg::CLK_JUMP_MC;
      ict_pkg::OP_LONG_JUMP_MCNE:    exec_clocks = ict_pkg::CLK_JUMP_MC;
      ict_pkg::OP_AND_REG_MEM:       exec_clocks = word_clocks(odd, narrow,
          ict_pkg::CLK_AND_RM_S, ict_pkg::CLK_AND_RM_L);
      ict_pkg::OP_AND_MEM_REG:       exec_clocks = word_clocks(odd, narrow,
          ict_pkg::CLK_AND_MR_S, ict_pkg::CLK_AND_MR_L);
      ict_pkg::OP_CALL:              exec_clocks = word_clocks(odd, 1'b0,
          ict_pkg::CLK_CALL_S, ict_pkg::CLK_CALL_L);
      ict_pkg::OP_TEST_AND_SET:      exec_clocks = dzero ?
          ict_pkg::CLK_TSL_Z : ict_pkg::CLK_TSL_NZ;
      ict_pkg::OP_JUMP:              exec_clocks = ict_pkg::CLK_JUMP;
      default:                       exec_clocks = ict_pkg::CLK_NO_OPERATION;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  // masked compare: upper byte masks lower byte against source byte
  logic mc_equal;
  // stall: grant or ready still withheld
  logic stall;
  // width_ok: no stray low code bits
  logic width_ok;
  always_comb begin
    mc_equal = ((src_value[7:0] ^ mask_compare[7:0]) &
                mask_compare[15:8]) == 8'h00;
    stall    = !(r.gnt_sync[1] && r.rdy_sync[1]);
    // width code: bit4 source is 16, bit3 dest is 16, low bits must be 0
    width_ok = (width_code[2:0] == 3'h0);
  end

  always_comb begin
    next_r          = r;
    // two-flop synchronisers for the bus pins
    next_r.gnt_sync = {r.gnt_sync[0], bus_grant};
    next_r.rdy_sync = {r.rdy_sync[0], mem_ready};
    // strobes fall back low each cycle
    next_r.save_we  = 1'b0;
    next_r.res_we   = 1'b0;
    next_r.done     = 1'b0;
    // software control of the interrupt enable bit
    if (int_control_we) begin
      next_r.sw[ict_pkg::SW_INT_CTRL_BIT] = int_control_in;
      if (!int_control_in) begin
        next_r.irq = 1'b0;
      end
    end
    case (r.st)
      // waiting for an instruction from the fetch unit
      ict_pkg::ICT_IDLE: begin
        if (issue_valid && r.ready) begin
          next_r.op      = issue_opcode;
          next_r.busy    = 1'b1;
          next_r.ready   = 1'b0;
          next_r.disp    = displacement;
          next_r.lng     = long_form;
          // next sequential address
          next_r.tp_next = r.tp + {21'h000000, instr_length};
          next_r.fetch_left = fetch_clocks;
          // execution count fixed at issue
          next_r.exec_left  = exec_clocks(issue_opcode, operand_is_reg,
                                          operand_odd, bus_is_8bit,
                                          dst_value[7:0] == 8'h00);
          next_r.elapsed = 7'h00;
          next_r.st      = ict_pkg::ICT_FETCH;
          // transfer and data decisions taken from the operand values
          case (issue_opcode)
            ict_pkg::OP_JUMP_WORD_NZ:   next_r.taken = src_value != 16'h0000;
            ict_pkg::OP_JUMP_WORD_Z:    next_r.taken = src_value == 16'h0000;
            ict_pkg::OP_JUMP_BYTE_NZ:   next_r.taken = src_value[7:0] != 8'h00;
            ict_pkg::OP_JUMP_BIT_CLEAR: next_r.taken =
                !src_value[bit_select];
            ict_pkg::OP_JUMP_MCE:       next_r.taken = mc_equal;
            ict_pkg::OP_LONG_JUMP_MCNE: begin
              next_r.taken = !mc_equal;
              next_r.lng   = 1'b1;
            end
            ict_pkg::OP_JUMP, ict_pkg::OP_CALL: next_r.taken = 1'b1;
            ict_pkg::OP_TEST_AND_SET:   next_r.taken = dst_value[7:0] != 8'h00;
            default:                    next_r.taken = 1'b0;
          endcase
        end
      end
      // fetch clocks run before execution counting starts
      ict_pkg::ICT_FETCH: begin
        // elapsed grows while stalled too
        if (!stall) begin
          next_r.elapsed = r.elapsed + 7'h01;
          if (r.fetch_left <= 6'h01) begin
            next_r.st = ict_pkg::ICT_EXEC;
          end
          next_r.fetch_left = r.fetch_left - 6'h01;
        end else begin
          next_r.elapsed = r.elapsed + 7'h01;
        end
      end
      // execution clocks, held while the bus is withheld
      ict_pkg::ICT_EXEC: begin
        // elapsed counts every clock; execution count only when the bus moves
        next_r.elapsed = r.elapsed + 7'h01;
        if (!stall) begin
          next_r.exec_left = r.exec_left - 6'h01;
          if (r.exec_left <= 6'h01) begin
            next_r.st = ict_pkg::ICT_DONE;
          end
        end
      end
      // retire: apply the instruction effect
      ict_pkg::ICT_DONE: begin
        next_r.done  = 1'b1;
        next_r.total = r.elapsed;
        next_r.ready = 1'b1;
        next_r.st    = ict_pkg::ICT_IDLE;
        // taken transfers add the offset
        next_r.tp    = r.taken ? r.tp_next + sext_disp(r.lng, r.disp)
                               : r.tp_next;
        // per-opcode retirement effects
        case (r.op)
          ict_pkg::OP_NO_OPERATION: begin
            next_r.tp = r.tp_next;
          end
          // halt keeps the pointer in place
          ict_pkg::OP_HALT: begin
            next_r.busy = 1'b0;
            next_r.tp   = r.tp;
          end
          ict_pkg::OP_INTERRUPT_REQUEST: begin
            next_r.sw[ict_pkg::SW_INT_SVC_BIT] = 1'b1;
            next_r.irq = r.sw[ict_pkg::SW_INT_CTRL_BIT];
          end
          ict_pkg::OP_SET_WIDTHS: begin
            if (width_ok) begin
              next_r.sw[ict_pkg::SW_SRC_WIDTH_BIT] = width_code[4];
              next_r.sw[ict_pkg::SW_DST_WIDTH_BIT] = width_code[3];
              next_r.werr = 1'b0;
            end else begin
              next_r.werr = 1'b1;
            end
          end
          ict_pkg::OP_AND_REG_MEM, ict_pkg::OP_AND_MEM_REG: begin
            // source is read only; result replaces destination
            next_r.res    = dst_value & src_value;
            next_r.res_we = 1'b1;
          end
          ict_pkg::OP_CALL: begin
            next_r.save    = r.tp_next;
            next_r.save_we = 1'b1;
          end
          ict_pkg::OP_TEST_AND_SET: begin
            if (!r.taken) begin
              next_r.res    = {8'h00, set_value};
              next_r.res_we = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // unused state code returns to idle
      default: next_r.st = ict_pkg::ICT_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  // reset: idle, ready, status cleared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r       <= '0;
      r.st    <= ict_pkg::ICT_IDLE;
      r.sw    <= ict_pkg::SW_RESET;
      r.tp    <= ict_pkg::TP_RESET;
      r.ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------------
  // outputs straight from the state record
  // --------------------------------------------------------------------
  // no logic between flops and pins
  assign issue_ready               = r.ready;
  assign busy                      = r.busy;
  assign channel_interrupt_request = r.irq;
  assign channel_status_word       = r.sw;
  assign task_pointer              = r.tp;
  assign return_address_save       = r.save;
  assign save_we                   = r.save_we;
  assign result_value              = r.res;
  assign result_we                 = r.res_we;
  assign width_error               = r.werr;
  assign instr_done                = r.done;
  assign instr_total_clocks        = r.total;

endmodule

`default_nettype wire
